// ### rtl/sync2.sv
/*
  Two-stage synchroniser for a vector of asynchronous levels.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

`default_nettype wire

// ### rtl/thermal_status_defines.svh
/*
  Constants of the thermal status flag block: bus address, register
  offsets, acknowledge bit count, reset values and valid-bit masks.
  Assumes inclusion by bare name from the block's design files.
*/
//
// Behaviour
// - A channel 6 reading above its critical limit sets critical status bit 5.
// - A channel 5 reading above its critical limit sets critical status bit 4.
// - A channel 4 reading above its critical limit sets critical status bit 3.
// - A channel 1 reading above its critical limit sets critical status bit 0.
// - An open or supply-tied channel 6 diode sets fault status bit 6.
// - An open or supply-tied channel 5 diode sets fault status bit 5.
// - An open or supply-tied channel 4 diode sets fault status bit 4.
// - An open or supply-tied channel 3 diode sets fault status bit 3.
// - An open or supply-tied channel 2 diode sets fault status bit 2.
// - An open or supply-tied channel 1 diode sets fault status bit 1.
// - The block answers on the two-wire bus only at address 1001101.
// - A channel flagged as faulty is skipped and gets no new reading.
// - A channel whose critical mask bit is one never drives the critical pin.
//
`ifndef THERMAL_STATUS_DEFINES_SVH
`define THERMAL_STATUS_DEFINES_SVH

`define TS_SLAVE_ADDR      7'h4D

`define TS_REG_CRIT_STATUS 8'h10
`define TS_REG_FAULT_STAT  8'h11
`define TS_REG_CRIT_MASK   8'h12

`define TS_CRIT_VALID      8'h39
`define TS_FAULT_VALID     8'h7E
`define TS_STATUS_RESET    8'h00
`define TS_MASK_RESET      8'h00

`define TS_ACK_BITCOUNT    4'h8

`endif

// ### rtl/thermal_status_flags.sv
/*
  Critical-temperature and diode-fault status flags with a two-wire
  bus slave for register reads and writes, and the critical pin.
  Assumes conversion results and limits arrive on clk; fault detectors
  and bus pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "thermal_status_defines.svh"

module thermal_status_flags
  import thermal_status_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Two-wire bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Conversion results
  input  wire logic       conv_valid,
  input  wire logic [2:0] conv_channel,
  input  wire logic [7:0] conv_temp,
  // Critical limits
  input  wire logic [7:0] ch1_crit_limit,
  input  wire logic [7:0] ch4_crit_limit,
  input  wire logic [7:0] ch5_crit_limit,
  input  wire logic [7:0] ch6_crit_limit,
  // Diode fault detectors, channels 6..1
  input  wire logic [5:0] sense_fault_det,
  // Sequencer skip flags, channels 6..1
  output logic      [5:0] ch_skip,
  // Critical pin, open drain
  output logic            critical_temp_out,
  output logic            critical_temp_out_oe
);

  localparam logic [7:0] CRIT_VALID  = `TS_CRIT_VALID;
  localparam logic [7:0] FAULT_VALID = `TS_FAULT_VALID;
  localparam logic [6:0] SLAVE_ADDR  = `TS_SLAVE_ADDR;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [5:0] fault_sync;
  logic       scl_s;
  logic       sda_s;

  // Bus pins reset to their idle high level, so no false edge follows
  sync2 #(
    .WIDTH     (8),
    .RESET_VAL (8'h03)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({sense_fault_det, scl_in, sda_in}),
    .dout  ({fault_sync, scl_s, sda_s})
  );

  //////////////////////////////////////////////////////////////////////////
  // Status and mask registers

  logic [7:0] crit_status;
  logic [7:0] fault_status;
  logic [7:0] crit_mask;
  logic       crit_oe;
  logic [7:0] next_crit_status;
  logic [7:0] next_fault_status;
  logic [7:0] next_crit_mask;
  logic       next_crit_oe;
  logic [7:0] limit_of [6];
  logic       wr_pulse;
  logic [7:0] ptr;
  logic [7:0] shreg;
  logic [7:0] rd_data;

  assign limit_of[0] = ch1_crit_limit;
  assign limit_of[1] = 8'h00;
  assign limit_of[2] = 8'h00;
  assign limit_of[3] = ch4_crit_limit;
  assign limit_of[4] = ch5_crit_limit;
  assign limit_of[5] = ch6_crit_limit;

  // One critical bit per channel 1, 4, 5 and 6; bit i belongs to channel i+1
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_crit
      if (CRIT_VALID[gi]) begin : g_used
        logic hit;
        assign hit = conv_valid && conv_channel == 3'(gi + 1)
                     && !fault_status[gi + 1];
        // Level follows the latest conversion of the channel
        assign next_crit_status[gi] = hit ?
          ($signed(conv_temp) > $signed(limit_of[gi])) :
          crit_status[gi];
      end else begin : g_rsvd
        assign next_crit_status[gi] = 1'b0;
      end
    end
  endgenerate
  assign next_crit_status[7:6] = 2'b00;

  always_comb begin
    next_fault_status = {1'b0, fault_sync, 1'b0};
    next_crit_mask    = crit_mask;
    if (wr_pulse && ptr == `TS_REG_CRIT_MASK) begin
      next_crit_mask = shreg & CRIT_VALID;
    end
    next_crit_oe = |(crit_status & ~crit_mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crit_status  <= `TS_STATUS_RESET;
      fault_status <= `TS_STATUS_RESET;
      crit_mask    <= `TS_MASK_RESET;
      crit_oe      <= 1'b0;
    end else begin
      crit_status  <= next_crit_status;
      fault_status <= next_fault_status;
      crit_mask    <= next_crit_mask;
      crit_oe      <= next_crit_oe;
    end
  end

  assign ch_skip              = fault_status[6:1];
  assign critical_temp_out    = 1'b0;
  assign critical_temp_out_oe = crit_oe;

  always_comb begin
    case (ptr)
      `TS_REG_CRIT_STATUS: rd_data = crit_status;
      `TS_REG_FAULT_STAT:  rd_data = fault_status;
      `TS_REG_CRIT_MASK:   rd_data = crit_mask;
      default:             rd_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-wire bus slave

  slave_state_t state;
  slave_state_t next_state;
  logic [3:0]   bitcnt;
  logic [3:0]   next_bitcnt;
  logic [1:0]   byte_idx;
  logic [1:0]   next_byte_idx;
  logic         is_read;
  logic         next_is_read;
  logic [7:0]   next_shreg;
  logic [7:0]   txreg;
  logic [7:0]   next_txreg;
  logic [7:0]   next_ptr;
  logic         sda_drive;
  logic         next_sda_drive;
  logic         scl_d;
  logic         sda_d;
  logic         scl_rise;
  logic         scl_fall;
  logic         bus_start;
  logic         bus_stop;

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;

  always_comb begin
    next_state     = state;
    next_bitcnt    = bitcnt;
    next_byte_idx  = byte_idx;
    next_is_read   = is_read;
    next_shreg     = shreg;
    next_txreg     = txreg;
    next_ptr       = ptr;
    next_sda_drive = sda_drive;
    wr_pulse       = 1'b0;
    if (bus_start) begin
      next_state     = ST_RX;
      next_bitcnt    = 4'h0;
      next_byte_idx  = 2'h0;
      next_is_read   = 1'b0;
      next_sda_drive = 1'b0;
    end else if (bus_stop) begin
      next_state     = ST_IDLE;
      next_sda_drive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sda_drive = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = 4'(bitcnt + 4'h1);
          end else if (scl_fall && bitcnt == `TS_ACK_BITCOUNT) begin
            next_bitcnt = 4'h0;
            if (byte_idx == 2'h0) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                next_sda_drive = 1'b1;
                next_is_read   = shreg[0];
                next_state     = ST_RX_ACK;
              end else begin
                next_state = ST_IDLE;
              end
            end else begin
              next_sda_drive = 1'b1;
              next_state     = ST_RX_ACK;
              if (byte_idx == 2'h1) begin
                next_ptr = shreg;
              end else begin
                wr_pulse = 1'b1;
              end
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            if (is_read) begin
              next_state     = ST_TX;
              next_txreg     = rd_data;
              next_sda_drive = ~rd_data[7];
            end else begin
              next_state     = ST_RX;
              next_sda_drive = 1'b0;
              if (byte_idx != 2'h2) begin
                next_byte_idx = 2'(byte_idx + 2'h1);
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bitcnt = 4'(bitcnt + 4'h1);
          end else if (scl_fall) begin
            if (bitcnt == `TS_ACK_BITCOUNT) begin
              next_bitcnt    = 4'h0;
              next_sda_drive = 1'b0;
              next_state     = ST_TX_ACK;
            end else begin
              next_txreg     = {txreg[6:0], 1'b0};
              next_sda_drive = ~txreg[6];
            end
          end
        end
        ST_TX_ACK: begin
          // Master not-acknowledge ends the read
          if (scl_rise && sda_s) begin
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            next_state     = ST_TX;
            next_txreg     = rd_data;
            next_sda_drive = ~rd_data[7];
          end
        end
        default: begin
          next_state     = ST_IDLE;
          next_sda_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= ST_IDLE;
      bitcnt    <= 4'h0;
      byte_idx  <= 2'h0;
      is_read   <= 1'b0;
      shreg     <= 8'h00;
      txreg     <= 8'h00;
      ptr       <= 8'h00;
      sda_drive <= 1'b0;
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
    end else begin
      state     <= next_state;
      bitcnt    <= next_bitcnt;
      byte_idx  <= next_byte_idx;
      is_read   <= next_is_read;
      shreg     <= next_shreg;
      txreg     <= next_txreg;
      ptr       <= next_ptr;
      sda_drive <= next_sda_drive;
      scl_d     <= scl_s;
      sda_d     <= sda_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_drive;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  property p_crit(int b);
    conv_valid && conv_channel == 3'(b + 1) && !fault_status[b + 1] |=>
      crit_status[b] ==
      ($signed($past(conv_temp)) > $signed($past(limit_of[b])));
  endproperty

  property p_fault(int k);
    sense_fault_det[k - 1] [*5] |-> fault_status[k];
  endproperty

  sequence s_addr_done;
    state == ST_RX && byte_idx == 2'h0 && scl_fall && bitcnt == 4'h8;
  endsequence

  chk_crit_ch6: assert property (p_crit(5))
    else $error("channel 6 critical bit wrong");
  chk_crit_ch5: assert property (p_crit(4))
    else $error("channel 5 critical bit wrong");
  chk_crit_ch4: assert property (p_crit(3))
    else $error("channel 4 critical bit wrong");
  chk_crit_ch1: assert property (p_crit(0))
    else $error("channel 1 critical bit wrong");
  chk_fault_ch6: assert property (p_fault(6))
    else $error("channel 6 fault bit not set");
  chk_fault_ch5: assert property (p_fault(5))
    else $error("channel 5 fault bit not set");
  chk_fault_ch4: assert property (p_fault(4))
    else $error("channel 4 fault bit not set");
  chk_fault_ch3: assert property (p_fault(3))
    else $error("channel 3 fault bit not set");
  chk_fault_ch2: assert property (p_fault(2))
    else $error("channel 2 fault bit not set");
  chk_fault_ch1: assert property (p_fault(1))
    else $error("channel 1 fault bit not set");
  chk_addr_match: assert property (
    s_addr_done ##0 shreg[7:1] == SLAVE_ADDR
    |=> sda_oe && state == ST_RX_ACK)
    else $error("own address not acknowledged");
  chk_addr_other: assert property (
    s_addr_done ##0 shreg[7:1] != SLAVE_ADDR
    |=> !sda_oe && state == ST_IDLE)
    else $error("foreign address acknowledged");
  chk_skip_faulty: assert property (
    conv_valid && fault_status[conv_channel] |=> $stable(crit_status))
    else $error("faulty channel reading used");
  chk_mask_pin: assert property (
    (crit_status & ~crit_mask) == 8'h00 |=> !critical_temp_out_oe)
    else $error("masked channel drove critical pin");
  chk_rsvd_zero: assert property (
    (crit_status & ~CRIT_VALID) == 8'h00 &&
    (fault_status & ~FAULT_VALID) == 8'h00)
    else $error("reserved status bit set");
  chk_read_load: assert property (
    state == ST_RX_ACK && scl_fall && is_read && !bus_start && !bus_stop
    |=> txreg == $past(rd_data))
    else $error("read byte not loaded from register");

endmodule

`default_nettype wire

// ### rtl/thermal_status_pkg.sv
/*
  Types of the thermal status flag block.
  Assumes nothing of its surroundings.
*/
package thermal_status_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } slave_state_t;

endpackage

// ### test/smbus_host.sv
/*
  Two-wire bus host model: start, stop, byte transfer, and register
  write and read by command byte.
  Assumes open-drain wiring with the pull-ups made by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module smbus_host (
  // Clock
  input  wire logic clk,
  // Bus
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase of 12 clocks, above the 10 the slave needs
  task automatic hold();
    repeat (12) @(negedge clk);
  endtask

  // Also serves as repeated start
  task automatic start();
    hold();
    sda_low = 1'h0;
    hold();
    scl_low = 1'h0;
    hold();
    sda_low = 1'h1;
    hold();
    scl_low = 1'h1;
  endtask

  task automatic stop();
    hold();
    sda_low = 1'h1;
    hold();
    scl_low = 1'h0;
    hold();
    sda_low = 1'h0;
    hold();
  endtask

  // Data moves only well after scl falls, never beside the edge
  task automatic bit_io(input logic b, output logic r);
    repeat (4) @(negedge clk);
    sda_low = ~b;
    hold();
    scl_low = 1'h0;
    hold();
    r = sda_line;
    scl_low = 1'h1;
  endtask

  // Ninth bit always released: ack slot on writes, nack on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'h1, r);
    ack = ~r;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd,
                           input logic [7:0] data, output logic ack);
    logic [7:0] q;
    logic       a0, a1, a2;
    start();
    xfer({addr, 1'h0}, q, a0);
    xfer(cmd, q, a1);
    xfer(data, q, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd,
                          output logic [7:0] data, output logic ack);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start();
    xfer({addr, 1'h0}, q, a0);
    xfer(cmd, q, a1);
    start();
    xfer({addr, 1'h1}, q, a2);
    xfer(8'hFF, data, a3);
    stop();
    ack = a0 & a1 & a2;
  endtask

  // Receive byte: reads the register the last pointer names
  task automatic recv_reg(input logic [6:0] addr, output logic [7:0] data,
                          output logic ack);
    logic [7:0] q;
    logic       a0, a1;
    start();
    xfer({addr, 1'h1}, q, a0);
    xfer(8'hFF, data, a1);
    stop();
    ack = a0;
  endtask
endmodule

`default_nettype wire

// ### test/thermal_status_flags_tb_top.sv
/*
  Self-checking bench of the thermal status flags: register reads over
  the two-wire bus, conversions, fault levels and the critical pin.
  Assumes the host model drives the bus; pull-ups are made here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "thermal_status_defines.svh"

module thermal_status_flags_tb_top;
  logic       clk, reset, conv_valid, ack;
  logic [2:0] conv_channel;
  logic [7:0] conv_temp, rd;
  logic [7:0] lims[4] = '{8'h50, 8'h40, 8'h30, 8'h20};
  logic [5:0] fault_det, ch_skip;
  logic       scl_low, host_sda_low, sda_out, sda_oe, crit_out, crit_oe;
  logic       sda_line, crit_pin;
  int         err_count, n_compared;
  int         chs[4] = '{1, 4, 5, 6};
  int         bits[4] = '{0, 3, 4, 5};

  assign sda_line = ~host_sda_low & ~(sda_oe & ~sda_out);
  assign crit_pin = ~(crit_oe & ~crit_out);

  always #2.5 clk = ~clk;

  smbus_host u_smbus_host (
    .clk      (clk),
    .sda_line (sda_line),
    .scl_low  (scl_low),
    .sda_low  (host_sda_low)
  );

  thermal_status_flags u_thermal_status_flags (
    .clk                  (clk),
    .reset                (reset),
    .scl_in               (~scl_low),
    .sda_in               (sda_line),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .conv_valid           (conv_valid),
    .conv_channel         (conv_channel),
    .conv_temp            (conv_temp),
    .ch1_crit_limit       (lims[0]),
    .ch4_crit_limit       (lims[1]),
    .ch5_crit_limit       (lims[2]),
    .ch6_crit_limit       (lims[3]),
    .sense_fault_det      (fault_det),
    .ch_skip              (ch_skip),
    .critical_temp_out    (crit_out),
    .critical_temp_out_oe (crit_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic rd_chk(logic [7:0] cmd, logic [7:0] exp);
    u_smbus_host.read_reg(`TS_SLAVE_ADDR, cmd, rd, ack);
    check1("read ack", 1'h1, ack);
    check8("read data", exp, rd);
  endtask

  task automatic wr(logic [7:0] cmd, logic [7:0] data);
    u_smbus_host.write_reg(`TS_SLAVE_ADDR, cmd, data, ack);
    check1("write ack", 1'h1, ack);
  endtask

  // Status lands 1 clock after the take, the pin 1 clock later
  task automatic convert(int ch, logic [7:0] temp);
    @(negedge clk);
    conv_valid = 1'h1;
    conv_channel = ch[2:0];
    conv_temp = temp;
    @(negedge clk);
    conv_valid = 1'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic end_test(string name);
    $display("Test %s done, mismatches so far %0d", name, err_count);
  endtask

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    reset = 1'h1;
    conv_valid = 1'h0;
    conv_channel = 3'h0;
    conv_temp = 8'h00;
    fault_det = 6'h00;
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'h0;
    repeat (10) @(negedge clk);
    check8("skip", 8'h00, {2'h0, ch_skip});
    check1("pin", 1'h1, crit_pin);
    rd_chk(`TS_REG_CRIT_STATUS, 8'h00);
    rd_chk(`TS_REG_FAULT_STAT, 8'h00);
    end_test("reset");
    for (int i = 0; i < 4; i++) begin
      convert(chs[i], 8'(lims[i] + 8'h01));
      check1("pin", 1'h0, crit_pin);
      rd_chk(`TS_REG_CRIT_STATUS, 8'h01 << bits[i]);
      convert(chs[i], lims[i]);
      rd_chk(`TS_REG_CRIT_STATUS, 8'h00);
    end
    convert(1, 8'hF0);
    rd_chk(`TS_REG_CRIT_STATUS, 8'h00);
    convert(2, 8'h7F);
    rd_chk(`TS_REG_CRIT_STATUS, 8'h00);
    end_test("critical");
    wr(`TS_REG_CRIT_MASK, 8'h08);
    rd_chk(`TS_REG_CRIT_MASK, 8'h08);
    convert(4, 8'h51);
    check1("pin", 1'h1, crit_pin);
    rd_chk(`TS_REG_CRIT_STATUS, 8'h08);
    convert(1, 8'h51);
    check1("pin", 1'h0, crit_pin);
    wr(`TS_REG_CRIT_MASK, 8'hFF);
    rd_chk(`TS_REG_CRIT_MASK, 8'h39);
    check1("pin", 1'h1, crit_pin);
    u_smbus_host.recv_reg(`TS_SLAVE_ADDR, rd, ack);
    check1("receive ack", 1'h1, ack);
    check8("receive data", 8'h39, rd);
    convert(1, 8'h00);
    convert(4, 8'h00);
    wr(`TS_REG_CRIT_MASK, 8'h00);
    end_test("mask");
    u_smbus_host.read_reg(7'h4C, `TS_REG_CRIT_STATUS, rd, ack);
    check1("foreign addr ack", 1'h0, ack);
    wr(`TS_REG_CRIT_STATUS, 8'hFF);
    rd_chk(`TS_REG_CRIT_STATUS, 8'h00);
    rd_chk(8'h20, 8'h00);
    end_test("bus");
    for (int k = 0; k < 6; k++) begin
      fault_det = 6'h01 << k;
      repeat (5) @(negedge clk);
      check8("skip", 8'h01 << k, {2'h0, ch_skip});
      rd_chk(`TS_REG_FAULT_STAT, 8'h02 << k);
    end
    fault_det = 6'h01;
    repeat (5) @(negedge clk);
    convert(1, 8'h7F);
    rd_chk(`TS_REG_CRIT_STATUS, 8'h00);
    fault_det = 6'h00;
    repeat (5) @(negedge clk);
    convert(1, 8'h7F);
    rd_chk(`TS_REG_CRIT_STATUS, 8'h01);
    end_test("fault");
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule

`default_nettype wire
